// ==== cpnw_pkg.sv ====
// Purpose: Shared constants, types and register map of the partial network wake filter
// Assumes: 10 MHz core clock, 8-bit register data
// Notes:   Register offsets are register indices on the Avalon word address
package cpnw_pkg;
	localparam int unsigned CLK_HZ = 10_000_000;
	// ----------------------------------------------------------------
	// Register indices
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL   = 8'h20;
	localparam logic [7:0] REG_STATUS = 8'h22;
	localparam logic [7:0] REG_RATE   = 8'h26;
	localparam logic [7:0] REG_IDM0   = 8'h27;
	localparam logic [7:0] REG_FCTL   = 8'h2f;
	localparam logic [7:0] REG_WCTL   = 8'h30;
	localparam logic [7:0] REG_EVENT  = 8'h31;
	localparam logic [7:0] REG_DM0    = 8'h68;
	localparam logic [7:0] REG_DM7    = 8'h6f;
	// ----------------------------------------------------------------
	// Fields and reset values
	// ----------------------------------------------------------------
	localparam int unsigned CTRL_FDT   = 6;
	localparam int unsigned CTRL_VALID = 5;
	localparam int unsigned CTRL_SWE   = 4;
	localparam int unsigned FCTL_IDE   = 7;
	localparam int unsigned FCTL_DEM   = 6;
	localparam int unsigned EV_WAKE    = 0;
	localparam int unsigned EV_FDE     = 1;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] FCTL_RST = 8'h40;
	localparam logic [7:0] CFG_RST  = 8'h00;
	localparam logic [2:0] RATE_RST = 3'h5;
	localparam logic [1:0] MODE_OFFLINE = 2'h0;
	localparam logic [1:0] MODE_ACT_UV  = 2'h1;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned RATE_50K  = 50_000;
	localparam int unsigned RATE_100K = 100_000;
	localparam int unsigned RATE_125K = 125_000;
	localparam int unsigned RATE_250K = 250_000;
	localparam int unsigned RATE_500K = 500_000;
	localparam int unsigned RATE_1M   = 1_000_000;
	localparam logic [7:0] CYC_50K  = 8'(CLK_HZ / RATE_50K);
	localparam logic [7:0] CYC_100K = 8'(CLK_HZ / RATE_100K);
	localparam logic [7:0] CYC_125K = 8'(CLK_HZ / RATE_125K);
	localparam logic [7:0] CYC_250K = 8'(CLK_HZ / RATE_250K);
	localparam logic [7:0] CYC_500K = 8'(CLK_HZ / RATE_500K);
	localparam logic [7:0] CYC_1M   = 8'(CLK_HZ / RATE_1M);
	localparam int unsigned T_WAKE_DOM_NS = 5000;
	localparam int unsigned T_WAKE_REC_NS = 5000;
	localparam logic [15:0] WAKE_DOM_CYC = 16'((T_WAKE_DOM_NS * (CLK_HZ / 1_000_000) + 999) / 1000);
	localparam logic [15:0] WAKE_REC_CYC = 16'((T_WAKE_REC_NS * (CLK_HZ / 1_000_000) + 999) / 1000);
	localparam logic [3:0] IDLE_BITS = 4'hb;
	localparam logic [5:0] ERR_OVF   = 6'h20;
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] address;
		logic       read;
		logic       write;
		logic [7:0] writedata;
	} cpnw_avs_s;
	typedef struct packed {
		logic active;
		logic osc_locked;
		logic supply_low;
		logic tx_timeout;
	} cpnw_phy_s;
	typedef enum logic [3:0] {
		ST_IDLE, ST_WAIT, ST_ID, ST_SRR, ST_IDE, ST_EXT, ST_RTR, ST_FDF, ST_R0, ST_DLC, ST_DATA, ST_CRC, ST_DEL
	} cpnw_state_e;
endpackage

// ==== cpnw_sync.sv ====
// Purpose: Two-stage synchroniser for asynchronous levels
// Assumes: Inputs are slow levels
// Notes:   First stage feeds only the second
`timescale 1ns/100ps
module cpnw_sync #(
	parameter int unsigned W     = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         clock_i,
	input  wire logic         srst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] nxt_s1;
	logic [W-1:0] nxt_s2;
	always_comb begin
		nxt_s1 = srst_i ? INIT : d_i;
		nxt_s2 = srst_i ? INIT : s1_ff;
	end
	always_ff @(posedge clock_i) begin
		s1_ff <= nxt_s1;
		s2_ff <= nxt_s2;
	end
	assign q_o = s2_ff;
endmodule

// ==== cpnw_crc15.sv ====
// Purpose: Serial 15-bit CAN CRC
// Assumes: One bit per en_i pulse, MSB first
// Notes:   Feeding the received CRC too leaves zero on a good frame
`timescale 1ns/100ps
module cpnw_crc15 (
	input  wire logic        clock_i,
	input  wire logic        srst_i,
	input  wire logic        clr_i,
	input  wire logic        en_i,
	input  wire logic        bit_i,
	output logic      [14:0] crc_o
);
	localparam logic [14:0] POLY = 15'h4599;
	logic [14:0] crc_ff;
	logic [14:0] nxt_crc;
	always_comb begin
		nxt_crc = crc_ff;
		if (srst_i || clr_i) begin
			nxt_crc = 15'h0000;
		end else if (en_i) begin
			nxt_crc = {crc_ff[13:0], 1'b0} ^ ((bit_i ^ crc_ff[14]) ? POLY : 15'h0000);
		end
	end
	always_ff @(posedge clock_i) begin
		crc_ff <= nxt_crc;
	end
	assign crc_o = crc_ff;
endmodule

// ==== cpnw_wake_filter.sv ====
// Purpose: Selective wake-up filter with status register and Avalon-MM slave
// Assumes: rx_i is the raw bus receive level, 1 = recessive
// Notes:   Decoder resynchronises on every falling edge
// Operation
// - status bit 7 shows transceiver active mode
// - status bit 6 shows frame error or invalid config; then standard wake only
// - status bit 5 mirrors configuration-valid flag
// - status bit 4 shows oscillator at target frequency
// - status bit 3 set after bus silence timeout, clear on activity
// - status bit 1 shows supply below 90 %, only when mode is 01
// - status bit 0 shows transmitter disabled by dominant timeout
// - scan for wake frames only with both wake enables and valid config
// - format bit chooses 11-bit or 29-bit identifier match
// - mask bit 1 makes identifier bit don't care
// - nonzero length needs a data bit and mask bit both 1
// - without data evaluation, id match plus good CRC wakes
// - with data evaluation also need data frame, equal length, data match
// - error counter up on bad frame, down on good frame
// - counter above 31 sets frame error and wakes; cleared when disabled
// - software sets valid flag; config writes clear it
// - standard pattern wakes when selective wake off or config invalid
// - no bus wake unless offline mode and bus wake enabled
// - tolerated flexible frames decrement counter, never wake, wait for idle
// - untolerated flexible frames count as errors
// - wake sets bus wake event and drives receive output low
`timescale 1ns/100ps
module cpnw_wake_filter
	import cpnw_pkg::*;
#(
	parameter int unsigned TO_WAKE_CYC = 10000,
	parameter int unsigned SILENCE_CYC = 10000
) (
	input  wire logic            clock_i,
	input  wire logic            srst_i,
	input  wire cpnw_pkg::cpnw_avs_s avs_i,
	output logic      [7:0]      avs_readdata_o,
	output logic                 avs_waitrequest_o,
	input  wire cpnw_pkg::cpnw_phy_s phy_i,
	input  wire logic            rx_i,
	output logic                 rxd_o,
	output logic                 bus_wake_event_o
);
	import cpnw_pkg::*;
	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic      rx_s;
	cpnw_phy_s phy_s;
	cpnw_sync #(.W(1), .INIT(1'b1)) u_rx_sync (
		.clock_i (clock_i),
		.srst_i  (srst_i),
		.d_i     (rx_i),
		.q_o     (rx_s)
	);
	cpnw_sync #(.W(4), .INIT(4'h0)) u_phy_sync (
		.clock_i (clock_i),
		.srst_i  (srst_i),
		.d_i     (phy_i),
		.q_o     (phy_s)
	);
	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	logic [7:0] ctrl_ff, nxt_ctrl, fctl_ff, nxt_fctl, rdata_ff, nxt_rdata;
	logic [2:0] rate_ff, nxt_rate;
	logic [7:0] idm_ff [8];
	logic [7:0] nxt_idm [8];
	logic [7:0] dm_ff [8];
	logic [7:0] nxt_dm [8];
	logic       cwe_ff, nxt_cwe, ack_ff, nxt_ack, wake_ff, nxt_wake, fde_ff, nxt_fde;
	logic       we, cfg_we, wake_set, fde_set;
	logic [7:0] stat;
	logic       pn_config_valid, selective_wake_enable, fd_tolerance_enable, bus_silent_flag;
	logic [1:0] xcvr_mode_select;
	logic       offline, pn_active, std_en;
	assign pn_config_valid       = ctrl_ff[CTRL_VALID];
	assign selective_wake_enable = ctrl_ff[CTRL_SWE];
	assign fd_tolerance_enable   = ctrl_ff[CTRL_FDT];
	assign xcvr_mode_select      = ctrl_ff[1:0];
	assign offline   = (xcvr_mode_select == MODE_OFFLINE) && cwe_ff;
	assign pn_active = offline && selective_wake_enable && pn_config_valid && !fde_ff;
	assign std_en    = offline && !pn_active;
	assign stat = {phy_s.active,
		fde_ff || !pn_config_valid,
		pn_config_valid,
		phy_s.osc_locked,
		bus_silent_flag,
		1'b0,
		phy_s.supply_low && (xcvr_mode_select == MODE_ACT_UV),
		phy_s.tx_timeout};
	// One wait cycle, then the access completes
	assign avs_waitrequest_o = (avs_i.read || avs_i.write) && !ack_ff;
	assign we     = avs_i.write && ack_ff;
	assign cfg_we = we && ((avs_i.address >= REG_RATE && avs_i.address <= REG_FCTL) ||
		(avs_i.address >= REG_DM0 && avs_i.address <= REG_DM7));
	always_comb begin
		nxt_ack   = !srst_i && (avs_i.read || avs_i.write) && !ack_ff;
		nxt_ctrl  = ctrl_ff;
		nxt_fctl  = fctl_ff;
		nxt_rate  = rate_ff;
		nxt_cwe   = cwe_ff;
		nxt_idm   = idm_ff;
		nxt_dm    = dm_ff;
		nxt_rdata = rdata_ff;
		nxt_wake  = wake_ff;
		nxt_fde   = fde_ff;
		if (avs_i.read && !ack_ff) begin
			nxt_rdata = 8'h00;
			if (avs_i.address == REG_CTRL) nxt_rdata = {1'b0, ctrl_ff[6:4], 2'b00, ctrl_ff[1:0]};
			if (avs_i.address == REG_STATUS) nxt_rdata = stat;
			if (avs_i.address == REG_RATE) nxt_rdata = {5'h00, rate_ff};
			if (avs_i.address == REG_FCTL) nxt_rdata = {fctl_ff[7:6], 2'b00, fctl_ff[3:0]};
			if (avs_i.address == REG_WCTL) nxt_rdata = {7'h00, cwe_ff};
			if (avs_i.address == REG_EVENT) nxt_rdata = {6'h00, fde_ff, wake_ff};
			for (int i = 0; i < 8; i++) begin
				if (avs_i.address == REG_IDM0 + 8'(i)) nxt_rdata = idm_ff[i];
				if (avs_i.address == REG_DM0 + 8'(i)) nxt_rdata = dm_ff[i];
			end
		end
		if (we) begin
			if (avs_i.address == REG_CTRL) nxt_ctrl = avs_i.writedata;
			if (avs_i.address == REG_RATE) nxt_rate = avs_i.writedata[2:0];
			if (avs_i.address == REG_FCTL) nxt_fctl = avs_i.writedata;
			if (avs_i.address == REG_WCTL) nxt_cwe = avs_i.writedata[0];
			if (avs_i.address == REG_EVENT) begin
				nxt_wake = wake_ff && !avs_i.writedata[EV_WAKE];
				nxt_fde  = fde_ff && !avs_i.writedata[EV_FDE];
			end
			for (int i = 0; i < 8; i++) begin
				if (avs_i.address == REG_IDM0 + 8'(i)) nxt_idm[i] = avs_i.writedata;
				if (avs_i.address == REG_DM0 + 8'(i)) nxt_dm[i] = avs_i.writedata;
			end
		end
		if (cfg_we) nxt_ctrl[CTRL_VALID] = 1'b0;
		// Hardware set wins over a same-cycle clear
		if (wake_set) nxt_wake = 1'b1;
		if (fde_set) nxt_fde = 1'b1;
		if (srst_i) begin
			nxt_ctrl  = CTRL_RST;
			nxt_fctl  = FCTL_RST;
			nxt_rate  = RATE_RST;
			nxt_cwe   = 1'b0;
			nxt_rdata = 8'h00;
			nxt_wake  = 1'b0;
			nxt_fde   = 1'b0;
			for (int i = 0; i < 8; i++) begin
				nxt_idm[i] = CFG_RST;
				nxt_dm[i]  = CFG_RST;
			end
		end
	end
	always_ff @(posedge clock_i) begin
		ack_ff   <= nxt_ack;
		ctrl_ff  <= nxt_ctrl;
		fctl_ff  <= nxt_fctl;
		rate_ff  <= nxt_rate;
		cwe_ff   <= nxt_cwe;
		idm_ff   <= nxt_idm;
		dm_ff    <= nxt_dm;
		rdata_ff <= nxt_rdata;
		wake_ff  <= nxt_wake;
		fde_ff   <= nxt_fde;
	end
	assign avs_readdata_o   = rdata_ff;
	assign bus_wake_event_o = wake_ff;
	// ----------------------------------------------------------------
	// Bit timing, silence and standard wake pattern
	// ----------------------------------------------------------------
	logic [7:0]  bitcyc, tq_ff, nxt_tq;
	logic        prev_ff, nxt_prev, rxd_ff, nxt_rxd, edge_s, sample;
	logic [15:0] run_ff, nxt_run;
	logic [31:0] sil_ff, nxt_sil, to_ff, nxt_to;
	logic [1:0]  ph_ff, nxt_ph;
	logic        std_wake;
	always_comb begin
		case (rate_ff)
			3'h0: bitcyc = CYC_50K;
			3'h1: bitcyc = CYC_100K;
			3'h2: bitcyc = CYC_125K;
			3'h3: bitcyc = CYC_250K;
			3'h7: bitcyc = CYC_1M;
			default: bitcyc = CYC_500K;
		endcase
	end
	assign edge_s  = prev_ff != rx_s;
	assign sample  = tq_ff == (bitcyc >> 1);
	assign bus_silent_flag = sil_ff == SILENCE_CYC;
	assign std_wake = std_en && (ph_ff == 2'h2) && !rx_s && (run_ff == WAKE_DOM_CYC);
	always_comb begin
		nxt_prev = rx_s;
		nxt_tq   = (edge_s && !rx_s) || (tq_ff == bitcyc - 8'h01) ? 8'h00 : tq_ff + 8'h01;
		nxt_run  = edge_s ? 16'h0001 : (run_ff == 16'hffff ? run_ff : run_ff + 16'h0001);
		nxt_sil  = edge_s ? 32'h0 : (bus_silent_flag ? sil_ff : sil_ff + 32'h1);
		nxt_ph   = ph_ff;
		nxt_to   = (ph_ff == 2'h0) ? 32'h0 : to_ff + 32'h1;
		case (ph_ff)
			2'h0: if (!rx_s && run_ff == WAKE_DOM_CYC) nxt_ph = 2'h1;
			2'h1: if (rx_s && run_ff == WAKE_REC_CYC) nxt_ph = 2'h2;
			2'h2: if (std_wake) nxt_ph = 2'h0;
			default: nxt_ph = 2'h0;
		endcase
		if (!std_en || to_ff == TO_WAKE_CYC) nxt_ph = 2'h0;
		// Receive output held low while a wake is pending
		nxt_rxd = wake_ff ? 1'b0 : rx_s;
		if (srst_i) begin
			nxt_prev = 1'b1;
			nxt_tq   = 8'h00;
			nxt_run  = 16'h0000;
			nxt_sil  = 32'h0;
			nxt_ph   = 2'h0;
			nxt_to   = 32'h0;
			nxt_rxd  = 1'b1;
		end
	end
	always_ff @(posedge clock_i) begin
		prev_ff <= nxt_prev;
		tq_ff   <= nxt_tq;
		run_ff  <= nxt_run;
		sil_ff  <= nxt_sil;
		ph_ff   <= nxt_ph;
		to_ff   <= nxt_to;
		rxd_ff  <= nxt_rxd;
	end
	assign rxd_o = rxd_ff;
	// ----------------------------------------------------------------
	// Frame decoder
	// ----------------------------------------------------------------
	cpnw_state_e st_ff, nxt_st;
	logic [28:0] id_ff, nxt_id, id_cfg, id_msk;
	logic [6:0]  cnt_ff, nxt_cnt, nbits, dm_base;
	logic [2:0]  srun_ff, nxt_srun;
	logic [3:0]  dlc_ff, nxt_dlc;
	logic [5:0]  err_ff, nxt_err;
	logic        last_ff, nxt_last, rtr_ff, nxt_rtr, ide_ff, nxt_ide, hit_ff, nxt_hit;
	logic        stuffed, is_stuff, stuff_err, dbit, crc_clr, crc_en;
	logic        f_ok, f_err, f_fdt, id_ok, data_ok;
	logic [14:0] crc;
	cpnw_crc15 u_crc (
		.clock_i (clock_i),
		.srst_i  (srst_i),
		.clr_i   (crc_clr),
		.en_i    (crc_en),
		.bit_i   (rx_s),
		.crc_o   (crc)
	);
	assign id_cfg  = {idm_ff[3][4:0], idm_ff[2], idm_ff[1], idm_ff[0]};
	assign id_msk  = {idm_ff[7][4:0], idm_ff[6], idm_ff[5], idm_ff[4]};
	assign stuffed = st_ff inside {ST_ID, ST_SRR, ST_IDE, ST_EXT, ST_RTR, ST_FDF, ST_R0, ST_DLC, ST_DATA, ST_CRC, ST_DEL};
	assign is_stuff  = stuffed && sample && srun_ff == 3'h5;
	assign stuff_err = is_stuff && rx_s == last_ff && st_ff != ST_DEL;
	assign dbit    = sample && stuffed && !is_stuff;
	assign crc_clr = st_ff == ST_WAIT;
	assign crc_en  = dbit && st_ff != ST_DEL;
	assign nbits   = (nxt_dlc > 4'h8) ? 7'h40 : {nxt_dlc[3:0], 3'b000};
	// Codes above eight still mean eight bytes, so masks start at zero
	assign dm_base = (dlc_ff > 4'h8) ? 7'h00 : 7'h08 - {3'h0, dlc_ff};
	// Identifier compare, received format must equal the selected one
	assign id_ok = (ide_ff == fctl_ff[FCTL_IDE]) && (fctl_ff[FCTL_IDE] ?
		((id_ff ^ id_cfg) & ~id_msk) == 29'h0 :
		((id_ff[10:0] ^ id_cfg[28:18]) & ~id_msk[28:18]) == 11'h000);
	assign data_ok = !fctl_ff[FCTL_DEM] || (!rtr_ff && dlc_ff == fctl_ff[3:0] &&
		(fctl_ff[3:0] == 4'h0 || hit_ff));
	assign f_ok  = dbit && st_ff == ST_DEL && rx_s && crc == 15'h0000;
	assign f_err = stuff_err || (dbit && st_ff == ST_DEL && !(rx_s && crc == 15'h0000)) ||
		(dbit && st_ff == ST_FDF && rx_s && !fd_tolerance_enable);
	assign f_fdt = dbit && st_ff == ST_FDF && rx_s && fd_tolerance_enable;
	assign wake_set = (f_ok && pn_active && id_ok && data_ok) || fde_set || std_wake;
	assign fde_set  = pn_active && err_ff == ERR_OVF;
	always_comb begin
		nxt_st   = st_ff;
		nxt_id   = id_ff;
		nxt_cnt  = cnt_ff;
		nxt_srun = srun_ff;
		nxt_last = last_ff;
		nxt_rtr  = rtr_ff;
		nxt_ide  = ide_ff;
		nxt_dlc  = dlc_ff;
		nxt_hit  = hit_ff;
		nxt_err  = err_ff;
		if (sample && stuffed) begin
			nxt_last = rx_s;
			nxt_srun = (rx_s == last_ff && !is_stuff) ? srun_ff + 3'h1 : 3'h1;
		end
		if (dbit) begin
			nxt_cnt = cnt_ff + 7'h01;
			case (st_ff)
				ST_ID, ST_EXT: nxt_id = {id_ff[27:0], rx_s};
				ST_SRR, ST_RTR: nxt_rtr = rx_s;
				ST_IDE: nxt_ide = rx_s;
				ST_DLC: nxt_dlc = {dlc_ff[2:0], rx_s};
				ST_DATA: nxt_hit = hit_ff || (rx_s && dm_ff[3'(dm_base + {3'h0, cnt_ff[6:3]})][3'h7 - cnt_ff[2:0]]);
				default: nxt_hit = hit_ff;
			endcase
			case (st_ff)
				ST_ID: if (cnt_ff == 7'h0a) begin nxt_st = ST_SRR; nxt_cnt = 7'h00; end
				ST_SRR: nxt_st = ST_IDE;
				ST_IDE: begin nxt_st = rx_s ? ST_EXT : ST_FDF; nxt_cnt = 7'h00; end
				ST_EXT: if (cnt_ff == 7'h11) nxt_st = ST_RTR;
				ST_RTR: nxt_st = ST_FDF;
				ST_FDF: begin nxt_st = rx_s ? ST_IDLE : (ide_ff ? ST_R0 : ST_DLC); nxt_cnt = 7'h00; end
				ST_R0: begin nxt_st = ST_DLC; nxt_cnt = 7'h00; end
				ST_DLC: if (cnt_ff == 7'h03) begin
					nxt_cnt = 7'h00;
					nxt_hit = 1'b0;
					nxt_st  = (nbits == 7'h00 || rtr_ff) ? ST_CRC : ST_DATA;
				end
				ST_DATA: if (cnt_ff == nbits - 7'h01) begin nxt_st = ST_CRC; nxt_cnt = 7'h00; end
				ST_CRC: if (cnt_ff == 7'h0e) nxt_st = ST_DEL;
				ST_DEL: begin nxt_st = ST_IDLE; nxt_cnt = 7'h00; end
				default: nxt_st = ST_IDLE;
			endcase
		end else if (sample) begin
			case (st_ff)
				ST_IDLE: begin
					nxt_cnt = rx_s ? cnt_ff + 7'h01 : 7'h00;
					if (rx_s && cnt_ff == {3'h0, IDLE_BITS} - 7'h01) nxt_st = ST_WAIT;
				end
				ST_WAIT: if (!rx_s) begin
					nxt_st   = ST_ID;
					nxt_cnt  = 7'h00;
					nxt_srun = 3'h1;
					nxt_last = 1'b0;
				end
				default: nxt_st = st_ff;
			endcase
		end
		if (stuff_err) begin
			nxt_st  = ST_IDLE;
			nxt_cnt = 7'h00;
		end
		if (f_err && err_ff != ERR_OVF) nxt_err = err_ff + 6'h01;
		if ((f_ok || f_fdt) && err_ff != 6'h00) nxt_err = err_ff - 6'h01;
		if (srst_i || !pn_active) begin
			nxt_st   = ST_IDLE;
			nxt_cnt  = 7'h00;
			nxt_err  = 6'h00;
			nxt_id   = 29'h0;
			nxt_srun = 3'h0;
			nxt_last = 1'b1;
			nxt_rtr  = 1'b0;
			nxt_ide  = 1'b0;
			nxt_dlc  = 4'h0;
			nxt_hit  = 1'b0;
		end
	end
	always_ff @(posedge clock_i) begin
		st_ff   <= nxt_st;
		id_ff   <= nxt_id;
		cnt_ff  <= nxt_cnt;
		srun_ff <= nxt_srun;
		last_ff <= nxt_last;
		rtr_ff  <= nxt_rtr;
		ide_ff  <= nxt_ide;
		dlc_ff  <= nxt_dlc;
		hit_ff  <= nxt_hit;
		err_ff  <= nxt_err;
	end
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_wait_one_cycle: assert property (@(posedge clock_i) disable iff (srst_i)
		(avs_i.read && !ack_ff) |=> !avs_waitrequest_o) else $error("access not answered after one wait");
	a_cfg_clears_valid: assert property (@(posedge clock_i) disable iff (srst_i)
		cfg_we |=> !stat[5] && stat[6]) else $error("config write left valid set");
	a_wake_rxd_low: assert property (@(posedge clock_i) disable iff (srst_i)
		wake_set |=> bus_wake_event_o ##1 !rxd_o) else $error("wake did not pull rxd low");
	a_online_no_wake: assert property (@(posedge clock_i) disable iff (srst_i)
		(xcvr_mode_select != MODE_OFFLINE || !cwe_ff) |-> !wake_set) else $error("wake while not offline");
	a_overflow_fde: assert property (@(posedge clock_i) disable iff (srst_i)
		(pn_active && err_ff == ERR_OVF) |=> stat[6] && bus_wake_event_o) else $error("overflow without error");
	a_idle_when_off: assert property (@(posedge clock_i) disable iff (srst_i)
		!pn_active |=> st_ff == ST_IDLE && err_ff == 6'h00) else $error("decoder ran while disabled");
	a_fd_tolerated: assert property (@(posedge clock_i) disable iff (srst_i)
		(f_fdt && pn_active && err_ff != 6'h00) |=> err_ff == $past(err_ff) - 6'h01 && st_ff == ST_IDLE)
		else $error("tolerated frame not decremented");
	a_fd_error: assert property (@(posedge clock_i) disable iff (srst_i)
		(dbit && st_ff == ST_FDF && rx_s && !fd_tolerance_enable && pn_active && err_ff != ERR_OVF) |=>
		err_ff == $past(err_ff) + 6'h01) else $error("flexible frame not counted as error");
	a_silence_clear: assert property (@(posedge clock_i) disable iff (srst_i)
		edge_s |=> !stat[3] [*2]) else $error("silent flag during activity");
	a_supply_gate: assert property (@(posedge clock_i) disable iff (srst_i)
		xcvr_mode_select != MODE_ACT_UV |-> !stat[1]) else $error("supply flag outside mode 01");
	c_frame_wake: cover property (@(posedge clock_i) disable iff (srst_i) f_ok && pn_active && id_ok && data_ok);
	c_fde_wake: cover property (@(posedge clock_i) disable iff (srst_i) fde_set);
	c_std_wake: cover property (@(posedge clock_i) disable iff (srst_i) std_wake);
	c_fd_frame: cover property (@(posedge clock_i) disable iff (srst_i) f_fdt);
endmodule

// ==== cpnw_bus_node.sv ====
// Purpose: Bus node model sending frames and wake patterns on rx
// Assumes: Bit time BIT_CYC clocks, recessive idle level
// Notes:   Standard frames with zero or one data byte only
`timescale 1ns/100ps
module cpnw_bus_node #(
	parameter int BIT_CYC = 20
) (
	input  wire logic clock_i,
	output logic      rx_o
);
	initial rx_o = 1'b1;
	task automatic put(input logic b, input int n);
		rx_o <= b;
		repeat (n) @(posedge clock_i);
	endtask
	task automatic pattern();
		put(1'b0, 55);
		put(1'b1, 55);
		put(1'b0, 55);
		put(1'b1, 80);
	endtask
	task automatic frame(input logic [10:0] id, input logic [3:0] dlc, input logic [7:0] d, input logic bad,
		input logic fd);
		logic [26:0] hdr;
		logic [41:0] f;
		logic [14:0] crc;
		logic        last;
		int          n;
		int          run;
		hdr = {1'b0, id, 2'b00, fd, dlc, d};
		n = (dlc != 4'h0) ? 27 : 19;
		crc = '0;
		for (int i = 26; i > 26 - n; i--) begin
			crc = {crc[13:0], 1'b0} ^ ((hdr[i] ^ crc[14]) ? 15'h4599 : 15'h0000);
		end
		crc[0] = crc[0] ^ bad;
		f = (n == 27) ? {hdr, crc} : {hdr[26:8], crc, 8'h00};
		last = 1'b1;
		run = 0;
		// Idle first, so a freshly enabled decoder sees the start of frame
		put(1'b1, 11 * BIT_CYC);
		for (int i = 41; i > 26 - n; i--) begin
			put(f[i], BIT_CYC);
			run = (f[i] == last) ? run + 1 : 1;
			last = f[i];
			if (run == 5) begin
				last = !last;
				put(last, BIT_CYC);
				run = 1;
			end
		end
		// Delimiter, empty ack slot, end of frame and intermission
		put(1'b1, 12 * BIT_CYC);
	endtask
endmodule

// ==== cpnw_wake_filter_tb.sv ====
// Purpose: Self-checking bench for the partial network wake filter
// Assumes: Wake and silence timeouts shortened by parameters
// Notes:   Expected values worked out by hand from the register map
`timescale 1ns/100ps
module cpnw_wake_filter_tb;
	import cpnw_pkg::*;
	logic       clock_i = 1'b0;
	logic       srst_i = 1'b1;
	cpnw_avs_s  avs = '0;
	cpnw_phy_s  phy = '0;
	logic [7:0] rdata;
	logic [7:0] q;
	logic       wrq;
	logic       rx;
	logic       rxd;
	logic       wake;
	int         n_errors = 0;
	int         total_checks = 0;
	int         cyc = 0;
	logic [24:0] tab [5] = '{{11'h1a5, 4'h1, 8'h50, 2'b00}, {11'h1a5, 4'h0, 8'h08, 2'b00},
		{11'h1a8, 4'h1, 8'h08, 2'b00}, {11'h1a5, 4'h1, 8'h08, 2'b10}, {11'h1a3, 4'h1, 8'h08, 2'b01}};
	cpnw_wake_filter #(.TO_WAKE_CYC(200), .SILENCE_CYC(300)) cpnw_wake_filter_inst (.clock_i(clock_i),
		.srst_i(srst_i), .avs_i(avs), .avs_readdata_o(rdata), .avs_waitrequest_o(wrq), .phy_i(phy),
		.rx_i(rx), .rxd_o(rxd), .bus_wake_event_o(wake));
	cpnw_bus_node #(.BIT_CYC(20)) cpnw_bus_node_inst (.clock_i(clock_i), .rx_o(rx));
	initial forever #50 clock_i = ~clock_i;
	task automatic finish_test();
		if (n_errors == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Request held until waitrequest is sampled low
	task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
		avs <= '{address: a, read: !wr, write: wr, writedata: d};
		do @(posedge clock_i); while (wrq !== 1'b0);
		q = rdata;
		avs <= '0;
		@(posedge clock_i);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		acc(1'b0, a, 8'h00);
		chk(q, exp);
	endtask
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 90000) begin
			n_errors++;
			finish_test();
		end
	end
	initial begin
		repeat (12) @(posedge clock_i);
		srst_i <= 1'b0;
		phy <= '{active: 1'b1, osc_locked: 1'b1, supply_low: 1'b1, tx_timeout: 1'b1};
		repeat (400) @(posedge clock_i);
		rd(REG_STATUS, 8'hd9);
		acc(1'b1, REG_CTRL, 8'h01);
		rd(REG_STATUS, 8'hdb);
		phy <= '0;
		acc(1'b1, REG_WCTL, 8'h01);
		cpnw_bus_node_inst.pattern();
		rd(REG_STATUS, 8'h40);
		acc(1'b1, REG_WCTL, 8'h00);
		acc(1'b1, REG_CTRL, 8'h00);
		cpnw_bus_node_inst.pattern();
		chk({7'h0, wake}, 8'h00);
		acc(1'b1, REG_WCTL, 8'h01);
		cpnw_bus_node_inst.pattern();
		chk({7'h0, wake}, 8'h01);
		chk({7'h0, rxd}, 8'h00);
		rd(REG_EVENT, 8'h01);
		acc(1'b1, REG_EVENT, 8'h01);
		acc(1'b1, REG_CTRL, 8'h20);
		acc(1'b1, 8'h2a, 8'h06);
		rd(REG_CTRL, 8'h00);
		acc(1'b1, 8'h29, 8'h80);
		acc(1'b1, 8'h2d, 8'h1c);
		acc(1'b1, REG_FCTL, 8'h41);
		acc(1'b1, REG_DM7, 8'ha8);
		acc(1'b1, REG_CTRL, 8'h30);
		for (int i = 0; i < 5; i++) begin
			cpnw_bus_node_inst.frame(tab[i][24:14], tab[i][13:10], tab[i][9:2], tab[i][1], 1'b0);
			chk({7'h0, wake}, {7'h0, tab[i][0]});
		end
		acc(1'b1, REG_EVENT, 8'h01);
		acc(1'b1, REG_FCTL, 8'h81);
		acc(1'b1, REG_CTRL, 8'h30);
		cpnw_bus_node_inst.frame(11'h1a5, 4'h1, 8'h50, 1'b0, 1'b0);
		chk({7'h0, wake}, 8'h00);
		acc(1'b1, REG_FCTL, 8'h01);
		acc(1'b1, REG_CTRL, 8'h30);
		cpnw_bus_node_inst.frame(11'h1a5, 4'h1, 8'h50, 1'b0, 1'b0);
		chk({7'h0, wake}, 8'h01);
		acc(1'b1, REG_EVENT, 8'h01);
		acc(1'b1, REG_CTRL, 8'h70);
		// One tolerated flexible frame keeps the count one short of overflow
		for (int i = 0; i < 33; i++) begin
			cpnw_bus_node_inst.frame(11'h1a5, 4'h1, 8'h08, i != 1, i == 1);
		end
		rd(REG_EVENT, 8'h00);
		acc(1'b1, REG_CTRL, 8'h30);
		cpnw_bus_node_inst.frame(11'h1a5, 4'h1, 8'h08, 1'b0, 1'b1);
		acc(1'b0, REG_EVENT, 8'h00);
		chk({7'h0, q[EV_FDE]}, 8'h01);
		acc(1'b0, REG_STATUS, 8'h00);
		chk({7'h0, q[6]}, 8'h01);
		finish_test();
	end
endmodule
